// file: inc/apm_regs.svh
// register offsets, field positions, reset values and timing counts for auto powerdown control
//
// Overview of operation
// - floppy drive pins disabled or floated in powerdown
// - local control and programming pins unaffected
// - floppy drive input pins stay inputs
// - motor, select, write pins float; others driven
// - serial direct powerdown via config bits 3, 7
// - serial auto powerdown only with enables 5, 6
// - transmitter sleeps when holding and shift empty
// - receiver sleeps when FIFO empty and idle
// - ring indicate changes still seen while asleep
// - transmit holding write wakes transmitter
// - receive line change wakes receiver
// - parallel direct powerdown via config bit 2
// - parallel auto powerdown only with enable bit 4
// - EPP asleep when EPP not configured
// - in ECP mode, EPP asleep unless selected
// - ECP asleep when ECP not configured
// - ECP asleep when standard, bidir, EPP selected
// - parallel state re-evaluated on mode change
// - floppy sleeps after 10 ms timer and idle
`ifndef APM_REGS_SVH
`define APM_REGS_SVH

`define APM_ADDR_W            4
`define APM_OFF_FDC_CFG       4'h0
`define APM_OFF_PAR_CFG       4'h1
`define APM_OFF_UART_CFG      4'h2
`define APM_OFF_AUTO_CFG      4'h7
`define APM_OFF_ECR_MODE      4'h8
`define APM_OFF_STATUS        4'h9

`define APM_FDC_PWR_BIT       3
`define APM_PAR_PWR_BIT       2
`define APM_PAR_MODE_LSB      0
`define APM_UART1_PWR_BIT     3
`define APM_UART2_PWR_BIT     7
`define APM_AUTO_PAR_BIT      4
`define APM_AUTO_U1_BIT       5
`define APM_AUTO_U2_BIT       6
`define APM_AUTO_FDC_BIT      7

`define APM_FDC_CFG_RST       8'h28
`define APM_PAR_CFG_RST       8'h9c
`define APM_UART_CFG_RST      8'h88
`define APM_AUTO_CFG_RST      8'h00
`define APM_ECR_RST           8'h00

`define APM_CLK_HZ            40000000
`define APM_FDC_TIMER_MS      10
`define APM_FDC_TIMER_CYC     ((`APM_CLK_HZ / 1000) * `APM_FDC_TIMER_MS)

`endif

// file: inc/apm_pkg.sv
// types for auto powerdown control
package apm_pkg;

	// configured parallel port mode in parallel_power_config bits 1:0
	typedef enum logic [1:0] {
		APM_PP_SPP = 2'h0,
		APM_PP_EPP = 2'h1,
		APM_PP_ECP = 2'h2,
		APM_PP_ECP_EPP = 2'h3
	} apm_pp_mode_t;

	// extended control mode field
	typedef enum logic [2:0] {
		APM_ECR_SPP = 3'h0,
		APM_ECR_BIDIR = 3'h1,
		APM_ECR_FIFO = 3'h2,
		APM_ECR_ECP = 3'h3,
		APM_ECR_EPP = 3'h4,
		APM_ECR_RSV = 3'h5,
		APM_ECR_TEST = 3'h6,
		APM_ECR_CFG = 3'h7
	} apm_ecr_t;

	// floppy auto powerdown sequence
	typedef enum logic [2:0] {
		APM_FDC_AWAKE = 3'b001,
		APM_FDC_COUNT = 3'b010,
		APM_FDC_SLEEP = 3'b100
	} apm_fdc_st_t;

endpackage

// file: hw/apm_ctrl.sv
// auto powerdown control for floppy, two serial ports and parallel port
`timescale 1ns/1ps
`include "apm_regs.svh"

module apm_ctrl
	import apm_pkg::*;
#(
	parameter int unsigned FDC_TIMER_CYC = `APM_FDC_TIMER_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// register port
	input  wire logic [`APM_ADDR_W-1:0] addr,
	input  wire logic [7:0]             wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic      [7:0]             rdata,
	// floppy controller status and access events
	input  wire logic                   fdc_motor_any,
	input  wire logic                   fdc_idle,
	input  wire logic                   fdc_head_unloaded,
	input  wire logic                   fdc_access,
	input  wire logic                   fdc_wake,
	// floppy drive pins from the controller core, and inputs from the drive
	input  wire logic [3:0]             core_motor_on,
	input  wire logic [3:0]             core_drive_select,
	input  wire logic                   core_write_data,
	input  wire logic                   core_write_gate,
	input  wire logic                   core_step_direction,
	input  wire logic                   core_step_pulse,
	input  wire logic                   core_head_side,
	input  wire logic                   core_density,
	input  wire logic [1:0]             core_rate,
	input  wire logic                   read_data_input,
	input  wire logic                   write_protect_input,
	input  wire logic                   track_zero_input,
	input  wire logic                   index_pulse_input,
	input  wire logic                   second_drive_present_input,
	input  wire logic                   disk_change_input,
	// floppy drive pins toward the drive, and drive inputs toward the core
	output logic      [3:0]             motor_on_outputs,
	output logic      [3:0]             motor_on_oe,
	output logic      [3:0]             drive_select_outputs,
	output logic      [3:0]             drive_select_oe,
	output logic                        write_data_output,
	output logic                        write_data_oe,
	output logic                        write_gate_output,
	output logic                        write_gate_oe,
	output logic                        step_direction_output,
	output logic                        step_pulse_output,
	output logic                        head_side_select_output,
	output logic                        density_select_output,
	output logic      [1:0]             rate_select_outputs,
	output logic                        fdd_pins_oe,
	output logic      [5:0]             fdd_inputs_to_core,
	// serial ports, index 0 and 1
	input  wire logic [1:0]             thr_empty,
	input  wire logic [1:0]             tsr_empty,
	input  wire logic [1:0]             rx_fifo_empty,
	input  wire logic [1:0]             rx_idle,
	input  wire logic [1:0]             thr_write,
	input  wire logic [1:0]             serial_receive_input,
	input  wire logic [1:0]             ring_indicate_input,
	output logic      [1:0]             ring_indicate_change,
	output logic      [1:0]             uart_tx_pd,
	output logic      [1:0]             uart_rx_pd,
	// parallel port and floppy powerdown
	output logic                        par_pd,
	output logic                        epp_pd,
	output logic                        ecp_pd,
	output logic                        fdc_pd
);

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [7:0] fdc_cfg_q;
	logic [7:0] par_cfg_q;
	logic [7:0] uart_cfg_q;
	logic [7:0] auto_cfg_q;
	logic [2:0] ecr_q;

	wire sel_fdc = (addr == `APM_OFF_FDC_CFG);
	wire sel_par = (addr == `APM_OFF_PAR_CFG);
	wire sel_uart = (addr == `APM_OFF_UART_CFG);
	wire sel_auto = (addr == `APM_OFF_AUTO_CFG);
	wire sel_ecr = (addr == `APM_OFF_ECR_MODE);
	wire sel_stat = (addr == `APM_OFF_STATUS);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			fdc_cfg_q  <= `APM_FDC_CFG_RST;
			par_cfg_q  <= `APM_PAR_CFG_RST;
			uart_cfg_q <= `APM_UART_CFG_RST;
			auto_cfg_q <= `APM_AUTO_CFG_RST;
			ecr_q      <= 3'h0;
		end else if (wr) begin
			if (sel_fdc) fdc_cfg_q <= wdata;
			if (sel_par) par_cfg_q <= wdata;
			if (sel_uart) uart_cfg_q <= wdata;
			if (sel_auto) auto_cfg_q <= wdata;
			if (sel_ecr) ecr_q <= wdata[7:5];
		end
	end

	logic [7:0] status_w;
	logic [7:0] rdata_d;

	assign status_w = {fdc_pd, ecp_pd, epp_pd, par_pd, uart_rx_pd, uart_tx_pd};

	// unmapped addresses read as zero
	assign rdata_d = sel_fdc  ? fdc_cfg_q :
	                 sel_par  ? par_cfg_q :
	                 sel_uart ? uart_cfg_q :
	                 sel_auto ? auto_cfg_q :
	                 sel_ecr  ? {ecr_q, 5'h00} :
	                 sel_stat ? status_w : 8'h00;

	always_ff @(posedge clk) begin
		if (!resetn) rdata <= 8'h00;
		else if (rd) rdata <= rdata_d;
		else rdata <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// floppy powerdown

	localparam logic [23:0] FDC_CYC = 24'(FDC_TIMER_CYC);

	apm_fdc_st_t fdc_st_q;
	logic [23:0] fdc_cnt_q;
	wire         fdc_auto_en = auto_cfg_q[`APM_AUTO_FDC_BIT];
	wire         fdc_cond = !fdc_motor_any && fdc_idle && fdc_head_unloaded;
	wire         fdc_direct = fdc_cfg_q[`APM_FDC_PWR_BIT];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			fdc_st_q  <= APM_FDC_AWAKE;
			fdc_cnt_q <= 24'h0;
		end else if (!fdc_auto_en) begin
			fdc_st_q  <= APM_FDC_AWAKE;
			fdc_cnt_q <= 24'h0;
		end else begin
			case (fdc_st_q)
				APM_FDC_AWAKE: begin
					fdc_st_q  <= APM_FDC_COUNT;
					fdc_cnt_q <= FDC_CYC;
				end
				APM_FDC_COUNT: begin
					if (fdc_access || fdc_wake) fdc_cnt_q <= FDC_CYC;
					else if (fdc_cnt_q != 24'h0) fdc_cnt_q <= fdc_cnt_q - 24'h1;
					else if (fdc_cond) fdc_st_q <= APM_FDC_SLEEP;
				end
				APM_FDC_SLEEP: begin
					if (fdc_wake) fdc_st_q <= APM_FDC_AWAKE;
				end
				default: fdc_st_q <= APM_FDC_AWAKE;
			endcase
		end
	end

	assign fdc_pd = fdc_direct || (fdc_st_q == APM_FDC_SLEEP);

	// motor, select and write outputs float; step, head, density and rate outputs stay driven
	assign motor_on_outputs = core_motor_on;
	assign motor_on_oe = {4{!fdc_pd}};
	assign drive_select_outputs = core_drive_select;
	assign drive_select_oe = {4{!fdc_pd}};
	assign write_data_output = core_write_data;
	assign write_data_oe = !fdc_pd;
	assign write_gate_output = core_write_gate;
	assign write_gate_oe = !fdc_pd;
	assign step_direction_output = core_step_direction;
	assign step_pulse_output = core_step_pulse;
	assign head_side_select_output = core_head_side;
	assign density_select_output = core_density;
	assign rate_select_outputs = core_rate;
	assign fdd_pins_oe = 1'b1;
	// inputs pass through unchanged in any state
	assign fdd_inputs_to_core = {read_data_input, write_protect_input, track_zero_input,
	                             index_pulse_input, second_drive_present_input,
	                             disk_change_input};

	////////////////////////////////////////////////////////////////////////////
	// serial ports

	logic [1:0] tx_sleep_q;
	logic [1:0] rx_sleep_q;
	logic [1:0] rxd_q;
	logic [1:0] ri_q;
	wire  [1:0] uart_auto_en = {auto_cfg_q[`APM_AUTO_U2_BIT], auto_cfg_q[`APM_AUTO_U1_BIT]};
	wire  [1:0] uart_direct = {uart_cfg_q[`APM_UART2_PWR_BIT], uart_cfg_q[`APM_UART1_PWR_BIT]};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_uart
			always_ff @(posedge clk) begin
				if (!resetn) begin
					tx_sleep_q[gi] <= 1'b0;
					rx_sleep_q[gi] <= 1'b0;
					rxd_q[gi]      <= 1'b1;
					ri_q[gi]       <= 1'b0;
				end else begin
					rxd_q[gi] <= serial_receive_input[gi];
					ri_q[gi]  <= ring_indicate_input[gi];
					if (!uart_auto_en[gi] || thr_write[gi])
						tx_sleep_q[gi] <= 1'b0;
					else if (thr_empty[gi] && tsr_empty[gi])
						tx_sleep_q[gi] <= 1'b1;
					if (!uart_auto_en[gi] || (serial_receive_input[gi] != rxd_q[gi]))
						rx_sleep_q[gi] <= 1'b0;
					else if (rx_fifo_empty[gi] && rx_idle[gi])
						rx_sleep_q[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// ring-indicate edge detect never gated by powerdown
	assign ring_indicate_change = ring_indicate_input ^ ri_q;
	assign uart_tx_pd = uart_direct | tx_sleep_q;
	assign uart_rx_pd = uart_direct | rx_sleep_q;

	////////////////////////////////////////////////////////////////////////////
	// parallel port

	apm_pp_mode_t pp_mode;
	apm_ecr_t     ecr_mode;
	wire          par_auto_en = auto_cfg_q[`APM_AUTO_PAR_BIT];
	wire          ecp_cfg;
	wire          epp_cfg;

	assign pp_mode = apm_pp_mode_t'(par_cfg_q[`APM_PAR_MODE_LSB +: 2]);
	assign ecr_mode = apm_ecr_t'(ecr_q);
	assign ecp_cfg = (pp_mode == APM_PP_ECP) || (pp_mode == APM_PP_ECP_EPP);
	assign epp_cfg = (pp_mode == APM_PP_EPP) || (pp_mode == APM_PP_ECP_EPP);

	// combinational from mode fields, so any mode change re-evaluates at once
	assign par_pd = par_cfg_q[`APM_PAR_PWR_BIT];
	assign epp_pd = par_pd || (par_auto_en && (!epp_cfg ||
	                (ecp_cfg && ecr_mode != APM_ECR_EPP)));
	assign ecp_pd = par_pd || (par_auto_en && (!ecp_cfg ||
	                ecr_mode == APM_ECR_SPP || ecr_mode == APM_ECR_BIDIR ||
	                ecr_mode == APM_ECR_EPP));

	////////////////////////////////////////////////////////////////////////////
	// assertions

	sequence s_tx_idle(i);
		uart_auto_en[i] && thr_empty[i] && tsr_empty[i] && !thr_write[i];
	endsequence

	sequence s_rx_idle(i);
		uart_auto_en[i] && rx_fifo_empty[i] && rx_idle[i] &&
		serial_receive_input[i] == rxd_q[i];
	endsequence

	a_tx_enters_sleep: assert property (@(posedge clk) disable iff (!resetn)
		s_tx_idle(0) |=> uart_tx_pd[0])
		else $error("transmitter did not power down when empty");

	a_tx_wakes_write: assert property (@(posedge clk) disable iff (!resetn)
		thr_write[0] && !uart_direct[0] |=> !uart_tx_pd[0])
		else $error("transmitter did not wake on holding write");

	a_rx_wakes_edge: assert property (@(posedge clk) disable iff (!resetn)
		(serial_receive_input[1] != rxd_q[1]) && !uart_direct[1] |=> !uart_rx_pd[1])
		else $error("receiver did not wake on line change");

	a_rx_needs_idle: assert property (@(posedge clk) disable iff (!resetn)
		$rose(rx_sleep_q[0]) |-> $past(rx_fifo_empty[0] && rx_idle[0]))
		else $error("receiver slept while busy");

	a_uart_auto_off: assert property (@(posedge clk) disable iff (!resetn)
		!uart_auto_en[1] |=> !tx_sleep_q[1] && !rx_sleep_q[1])
		else $error("serial auto powerdown without enable");

	a_uart1_auto_off: assert property (@(posedge clk) disable iff (!resetn)
		!uart_auto_en[0] |=> !tx_sleep_q[0] && !rx_sleep_q[0])
		else $error("serial port held asleep without enable");

	a_ri_change_seen: assert property (@(posedge clk) disable iff (!resetn)
		uart_rx_pd[0] && $changed(ring_indicate_input[0]) |-> ring_indicate_change[0])
		else $error("ring change lost in powerdown");

	a_fdd_float: assert property (@(posedge clk) disable iff (!resetn)
		fdc_pd |-> !write_gate_oe && !write_data_oe && motor_on_oe == 4'h0)
		else $error("drive pins driven in powerdown");

	a_fdc_timer: assert property (@(posedge clk) disable iff (!resetn)
		$rose(fdc_st_q == APM_FDC_SLEEP) |-> $past(fdc_cnt_q) == 24'h0 && $past(fdc_cond))
		else $error("floppy slept before timer expiry");

	a_fdc_auto_off: assert property (@(posedge clk) disable iff (!resetn)
		!fdc_auto_en |=> fdc_st_q != APM_FDC_SLEEP)
		else $error("floppy held asleep without enable");

	a_epp_ecr: assert property (@(posedge clk) disable iff (!resetn)
		par_auto_en && pp_mode == APM_PP_ECP_EPP && ecr_mode != APM_ECR_EPP |-> epp_pd)
		else $error("epp awake without ecr selection");

	a_ecp_std: assert property (@(posedge clk) disable iff (!resetn)
		par_auto_en && ecr_mode == APM_ECR_BIDIR |-> ecp_pd)
		else $error("ecp awake in bidirectional mode");

	a_rx_enters_sleep: assert property (@(posedge clk) disable iff (!resetn)
		s_rx_idle(0) |=> uart_rx_pd[0])
		else $error("receiver did not power down when idle");

	a_rx_enters_u2: assert property (@(posedge clk) disable iff (!resetn)
		s_rx_idle(1) |=> uart_rx_pd[1])
		else $error("second receiver did not power down");

	a_tx_enters_u2: assert property (@(posedge clk) disable iff (!resetn)
		s_tx_idle(1) |=> uart_tx_pd[1])
		else $error("second transmitter did not power down");

	a_tx_needs_empty: assert property (@(posedge clk) disable iff (!resetn)
		$rose(tx_sleep_q[1]) |-> $past(thr_empty[1] && tsr_empty[1]))
		else $error("transmitter slept while busy");

	a_uart1_direct: assert property (@(posedge clk) disable iff (!resetn)
		uart_cfg_q[`APM_UART1_PWR_BIT] |-> uart_tx_pd[0] && uart_rx_pd[0])
		else $error("first serial port awake in direct powerdown");

	a_uart2_direct: assert property (@(posedge clk) disable iff (!resetn)
		uart_cfg_q[`APM_UART2_PWR_BIT] |-> uart_tx_pd[1] && uart_rx_pd[1])
		else $error("second serial port awake in direct powerdown");

	a_rx_wakes_u1: assert property (@(posedge clk) disable iff (!resetn)
		(serial_receive_input[0] != rxd_q[0]) && !uart_direct[0] |=> !uart_rx_pd[0])
		else $error("first receiver did not wake on line change");

	a_ri_change_u2: assert property (@(posedge clk) disable iff (!resetn)
		uart_rx_pd[1] && $changed(ring_indicate_input[1]) |-> ring_indicate_change[1])
		else $error("second ring change lost in powerdown");

	a_fdc_direct: assert property (@(posedge clk) disable iff (!resetn)
		fdc_direct |-> fdc_pd)
		else $error("floppy awake in direct powerdown");

	a_fdd_select_float: assert property (@(posedge clk) disable iff (!resetn)
		fdc_pd |-> drive_select_oe == 4'h0)
		else $error("drive selects driven in powerdown");

	a_fdd_awake_drive: assert property (@(posedge clk) disable iff (!resetn)
		!fdc_pd |-> write_gate_oe && write_data_oe && (motor_on_oe & drive_select_oe) == 4'hf)
		else $error("drive pins floating while awake");

	a_fdc_restart: assert property (@(posedge clk) disable iff (!resetn)
		fdc_auto_en && fdc_access && fdc_st_q == APM_FDC_COUNT |=> fdc_cnt_q == FDC_CYC)
		else $error("floppy timer not restarted by access");

	a_fdc_wake: assert property (@(posedge clk) disable iff (!resetn)
		fdc_auto_en && fdc_wake && fdc_st_q == APM_FDC_SLEEP |=> fdc_st_q == APM_FDC_AWAKE)
		else $error("floppy did not wake on wake event");

	a_par_direct: assert property (@(posedge clk) disable iff (!resetn)
		par_cfg_q[`APM_PAR_PWR_BIT] |-> par_pd && epp_pd && ecp_pd)
		else $error("parallel logic awake in direct powerdown");

	a_par_auto_off: assert property (@(posedge clk) disable iff (!resetn)
		!par_auto_en && !par_pd |-> !epp_pd && !ecp_pd)
		else $error("parallel auto powerdown without enable");

	a_epp_not_cfg: assert property (@(posedge clk) disable iff (!resetn)
		par_auto_en && !epp_cfg |-> epp_pd)
		else $error("epp awake while not configured");

	a_ecp_not_cfg: assert property (@(posedge clk) disable iff (!resetn)
		par_auto_en && !ecp_cfg |-> ecp_pd)
		else $error("ecp awake while not configured");

	a_ecp_mode_sel: assert property (@(posedge clk) disable iff (!resetn)
		!par_pd && par_auto_en && ecp_cfg && ecr_mode == APM_ECR_ECP |-> !ecp_pd)
		else $error("ecp asleep with ecp mode selected");

endmodule

// file: bench/apm_periph.sv
// peripheral model: drive sense lines, serial receive lines and ring indicate
`timescale 1ns/1ps

module apm_periph (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [1:0] rx_flip,
	input  wire logic [1:0] ri_flip,
	output logic            read_data_input,
	output logic            write_protect_input,
	output logic            track_zero_input,
	output logic            index_pulse_input,
	output logic            second_drive_present_input,
	output logic            disk_change_input,
	output logic      [1:0] serial_receive_input,
	output logic      [1:0] ring_indicate_input
);
	logic [15:0] lfsr_q;

	// sense lines follow an LFSR stepped every cycle so a stuck path cannot pass by luck
	always @(posedge clk) begin
		if (!resetn) begin
			lfsr_q <= 16'hace1;
			serial_receive_input <= 2'h3;
			ring_indicate_input <= 2'h0;
		end else begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			serial_receive_input <= serial_receive_input ^ rx_flip;
			ring_indicate_input <= ring_indicate_input ^ ri_flip;
		end
	end
	assign {read_data_input, write_protect_input, track_zero_input, index_pulse_input,
		second_drive_present_input, disk_change_input} = lfsr_q[5:0];
endmodule

// file: bench/apm_ctrl_test.sv
// self-checking bench for the auto powerdown controller
`timescale 1ns/1ps

module apm_ctrl_test;
	import apm_pkg::*;
	localparam int TMR = 20;
	logic clk, resetn, wr, rd, rd_seen, fdc_motor_any, fdc_idle, fdc_head_unloaded;
	logic fdc_access, fdc_wake, core_write_data, core_write_gate, core_step_direction;
	logic core_step_pulse, core_head_side, core_density, write_data_output, write_data_oe;
	logic write_gate_output, write_gate_oe, step_direction_output, step_pulse_output;
	logic head_side_select_output, density_select_output, fdd_pins_oe, par_pd, epp_pd;
	logic ecp_pd, fdc_pd, read_data_input, write_protect_input, track_zero_input;
	logic index_pulse_input, second_drive_present_input, disk_change_input;
	logic [3:0] addr, core_motor_on, core_drive_select, motor_on_outputs, motor_on_oe;
	logic [3:0] drive_select_outputs, drive_select_oe;
	logic [7:0] wdata, rdata;
	logic [5:0] fdd_inputs_to_core;
	logic [1:0] core_rate, rate_select_outputs, thr_empty, tsr_empty, rx_fifo_empty, rx_idle;
	logic [1:0] thr_write, serial_receive_input, ring_indicate_input, ring_indicate_change;
	logic [1:0] uart_tx_pd, uart_rx_pd, rx_flip, ri_flip;
	logic [2:0] ev [4];
	logic [7:0] exp_q [$];
	int mismatches, checks, n;
	integer seed;

	apm_ctrl #(.FDC_TIMER_CYC(TMR)) uut (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
		.fdc_motor_any, .fdc_idle, .fdc_head_unloaded, .fdc_access, .fdc_wake, .core_motor_on,
		.core_drive_select, .core_write_data, .core_write_gate, .core_step_direction,
		.core_step_pulse, .core_head_side, .core_density, .core_rate, .read_data_input,
		.write_protect_input, .track_zero_input, .index_pulse_input, .second_drive_present_input,
		.disk_change_input, .motor_on_outputs, .motor_on_oe, .drive_select_outputs,
		.drive_select_oe, .write_data_output, .write_data_oe, .write_gate_output, .write_gate_oe,
		.step_direction_output, .step_pulse_output, .head_side_select_output,
		.density_select_output, .rate_select_outputs, .fdd_pins_oe, .fdd_inputs_to_core,
		.thr_empty, .tsr_empty, .rx_fifo_empty, .rx_idle, .thr_write, .serial_receive_input,
		.ring_indicate_input, .ring_indicate_change, .uart_tx_pd, .uart_rx_pd, .par_pd,
		.epp_pd, .ecp_pd, .fdc_pd);
	apm_periph peer (.clk, .resetn, .rx_flip, .ri_flip, .read_data_input,
		.write_protect_input, .track_zero_input, .index_pulse_input,
		.second_drive_present_input, .disk_change_input, .serial_receive_input,
		.ring_indicate_input);

	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		{core_motor_on, core_drive_select, core_write_data, core_write_gate,
			core_step_direction, core_step_pulse, core_head_side, core_density,
			core_rate} <= 16'($random(seed));
	end

	task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk) rd_seen <= rd;
	always @(negedge clk) begin
		if (rd_seen && exp_q.size() == 0) begin
			mismatches++;
			$display("MISMATCH rdata expected none seen %h", rdata);
		end else if (rd_seen) chk("rdata", rdata, exp_q.pop_front());
	end

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		repeat (2) @(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask

	task automatic pins(input logic pd);
		@(negedge clk);
		chk("fdd_oe", {motor_on_oe, drive_select_oe}, pd ? 8'h00 : 8'hff);
		chk("wr_oe", {6'h0, write_data_oe, write_gate_oe}, pd ? 8'h00 : 8'h03);
		chk("fdd_out", {motor_on_outputs, drive_select_outputs},
			{core_motor_on, core_drive_select});
		chk("wr_out", {6'h0, write_data_output, write_gate_output},
			{6'h0, core_write_data, core_write_gate});
		chk("active", {step_direction_output, step_pulse_output, head_side_select_output,
			density_select_output, rate_select_outputs, fdd_pins_oe, 1'b0},
			{core_step_direction, core_step_pulse, core_head_side, core_density, core_rate,
			2'b10});
		chk("fdd_in", {2'h0, fdd_inputs_to_core}, {2'h0, read_data_input,
			write_protect_input, track_zero_input, index_pulse_input,
			second_drive_present_input, disk_change_input});
	endtask

	function automatic logic [1:0] ppd(input logic [1:0] m, input logic [2:0] e);
		logic x;
		x = (e == APM_ECR_SPP) || (e == APM_ECR_BIDIR) || (e == APM_ECR_EPP);
		return {!m[1] || x, !(m[0] && (!m[1] || e == APM_ECR_EPP))};
	endfunction

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		seed = 32'h0c2e;
		{resetn, wr, rd, addr, wdata, fdc_access, fdc_wake, fdc_motor_any} = '0;
		{thr_write, rx_flip, ri_flip, tsr_empty, rx_idle} = '0;
		{core_motor_on, core_drive_select, core_write_data, core_write_gate} = '0;
		{core_step_direction, core_step_pulse, core_head_side, core_density, core_rate} = '0;
		{fdc_idle, fdc_head_unloaded, thr_empty, rx_fifo_empty} = 6'h3f;
		ev = '{APM_ECR_SPP, APM_ECR_BIDIR, APM_ECR_ECP, APM_ECR_EPP};
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd_reg(4'h0, 8'h28);
		rd_reg(4'h1, 8'h9c);
		rd_reg(4'h2, 8'h88);
		rd_reg(4'h7, 8'h00);
		rd_reg(4'hf, 8'h00);
		rd_reg(4'h9, 8'hff);
		pins(1'b1);
		$display("test reset done");
		wr_reg(4'h0, 8'h20);
		pins(1'b0);
		wr_reg(4'h2, 8'h08);
		rd_reg(4'h9, 8'h75);
		wr_reg(4'h2, 8'h80);
		rd_reg(4'h9, 8'h7a);
		wr_reg(4'h2, 8'h00);
		wr_reg(4'h7, 8'h20);
		rd_reg(4'h9, 8'h70);
		rx_idle <= 2'h3;
		rd_reg(4'h9, 8'h74);
		tsr_empty <= 2'h3;
		rd_reg(4'h9, 8'h75);
		@(posedge clk);
		thr_write <= 2'b01;
		thr_empty <= 2'b10;
		@(posedge clk);
		thr_write <= 2'b00;
		@(negedge clk);
		chk("tx_pd", {6'h0, uart_tx_pd}, 8'h00);
		@(posedge clk);
		rx_flip <= 2'b11;
		@(posedge clk);
		rx_flip <= 2'b00;
		@(posedge clk);
		@(negedge clk);
		chk("rx_pd", {6'h0, uart_rx_pd}, 8'h00);
		wr_reg(4'h2, 8'h88);
		@(posedge clk);
		ri_flip <= 2'b11;
		@(posedge clk);
		ri_flip <= 2'b00;
		@(negedge clk);
		chk("ri_chg", {6'h0, ring_indicate_change}, 8'h03);
		@(negedge clk);
		chk("ri_chg", {6'h0, ring_indicate_change}, 8'h00);
		wr_reg(4'h2, 8'h00);
		thr_empty <= 2'h3;
		wr_reg(4'h7, 8'h60);
		rd_reg(4'h9, 8'h7f);
		wr_reg(4'h7, 8'h00);
		rd_reg(4'h9, 8'h70);
		$display("test serial done");
		wr_reg(4'h2, 8'h88);
		wr_reg(4'h1, 8'h03);
		rd_reg(4'h9, 8'h0f);
		wr_reg(4'h1, 8'h07);
		rd_reg(4'h9, 8'h7f);
		wr_reg(4'h7, 8'h10);
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 4; k++) begin
				wr_reg(4'h1, {6'h0, 2'(m)});
				wr_reg(4'h8, {ev[k], 5'h0});
				rd_reg(4'h9, {1'b0, ppd(2'(m), ev[k]), 5'h0f});
			end
		end
		$display("test parallel done");
		wr_reg(4'h7, 8'h80);
		repeat (10) @(posedge clk);
		@(negedge clk);
		chk("fdc_pd", {7'h0, fdc_pd}, 8'h00);
		@(posedge clk);
		fdc_access <= 1'b1;
		@(posedge clk);
		fdc_access <= 1'b0;
		n = 0;
		while (fdc_pd !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk("fdc_wait", {7'h0, n >= TMR && n <= TMR + 2}, 8'h01);
		pins(1'b1);
		@(posedge clk);
		fdc_wake <= 1'b1;
		@(posedge clk);
		fdc_wake <= 1'b0;
		@(negedge clk);
		chk("fdc_pd", {7'h0, fdc_pd}, 8'h00);
		wr_reg(4'h7, 8'h00);
		repeat (3 * TMR) @(posedge clk);
		@(negedge clk);
		chk("fdc_pd", {7'h0, fdc_pd}, 8'h00);
		$display("test floppy done");
		wrap_up();
	end

	initial begin
		#(25 * 20000);
		mismatches++;
		wrap_up();
	end
endmodule
